// ---- bench/osc_source.sv ----
// Purpose: Behavioural timer crystal or external clock on the osc pin
// Assumes: Half period well above three pclk cycles
// Notes: Hold freezes the pin, as a stalled oscillator would
`timescale 1ns/1ps
`default_nettype none
module osc_source #(
  parameter int HALF_NS = 500
) (
  output logic timer_osc_input_pin,
  input wire logic hold
);
  // ==========================================================================
  // Free-running source, phase unrelated to pclk
  initial timer_osc_input_pin = 1'b0;
  always begin
    #(HALF_NS);
    if (!hold) begin
      timer_osc_input_pin = ~timer_osc_input_pin;
    end
  end
endmodule : osc_source
`default_nettype wire

// ---- bench/timer_async_ctrl_props.sv ----
// Purpose: Port-level checker for the async timer control block
// Assumes: APB writes are mirrored in small shadow registers
// Notes: Shadows lag a write, so relations wait for them to settle
`timescale 1ns/1ps
`default_nettype none
module timer_async_ctrl_props
  import timer_async_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_osc_input_pin,
  input wire logic global_irq_en,
  input wire logic [2:0] vector_ack,
  input wire logic [2:0] irq_req,
  input wire logic irq,
  input wire logic ext_buf_en,
  input wire logic xtal_en,
  input wire logic shared_prescaler_rst
);
  // ==========================================================================
  // Write shadows
  localparam logic [11:0] A_STAT = {ASYNC_CLOCK_STATUS_IDX, 2'b00};
  localparam logic [11:0] A_MASK = {TIMER_B_IRQ_MASK_IDX, 2'b00};
  localparam logic [11:0] A_GTC = {GENERAL_TIMER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_EMSK = {EVENT_MASK_IDX, 2'b00};
  logic wr_go;
  logic gtc_wr;
  logic rd_stat;
  logic [1:0] stat_reg;
  logic [2:0] mask_reg;
  logic [7:0] emask_reg;
  logic tsm_reg;
  assign wr_go = psel && penable && pready && pwrite;
  assign gtc_wr = wr_go && paddr == A_GTC;
  assign rd_stat = pready && !pwrite && paddr == A_STAT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 2'b00;
      mask_reg <= 3'b000;
      emask_reg <= 8'h00;
      tsm_reg <= 1'b0;
    end else if (wr_go) begin
      if (paddr == A_STAT) stat_reg <= pwdata[6:5];
      if (paddr == A_MASK) mask_reg <= pwdata[2:0];
      if (paddr == A_EMSK) emask_reg <= pwdata[7:0];
      if (paddr == A_GTC) tsm_reg <= pwdata[7];
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ext_buf_follow: assert property (
    ($stable(stat_reg))[*3] |-> ext_buf_en == (stat_reg[1] && stat_reg[0]))
    else $error("ext buffer enable wrong");
  a_xtal_follow: assert property (
    ($stable(stat_reg))[*3] |-> xtal_en == (!stat_reg[1] && stat_reg[0]))
    else $error("crystal enable wrong");
  a_global_gate: assert property (
    (!global_irq_en)[*2] |-> irq_req == 3'b000)
    else $error("irq request without global enable");
  a_mask_gate: assert property (
    ($stable(mask_reg))[*2] |-> (irq_req & ~mask_reg) == 3'b000)
    else $error("irq request with enable bit clear");
  a_event_mask: assert property (
    (emask_reg == 8'h00)[*2] |-> !irq)
    else $error("irq with all events masked");
  a_shared_pulse: assert property (
    !tsm_reg && !$past(tsm_reg) && shared_prescaler_rst
    |=> !shared_prescaler_rst)
    else $error("shared prescaler reset not cleared");
  a_sync_hold: assert property (
    (tsm_reg && !gtc_wr)[*2] ##0 shared_prescaler_rst |=> shared_prescaler_rst)
    else $error("shared reset dropped in sync mode");
  a_status_read: assert property (
    rd_stat |-> prdata[31:5] == {24'h00_0000, 1'b0, stat_reg})
    else $error("status read wrong");
  a_busy_sync_zero: assert property (
    ($stable(stat_reg))[*3] ##0 (rd_stat && !stat_reg[0])
    |-> prdata[4:0] == 5'h00)
    else $error("busy flag set in sync mode");
endmodule : timer_async_ctrl_props

bind timer_async_ctrl timer_async_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .timer_osc_input_pin(timer_osc_input_pin), .global_irq_en(global_irq_en),
  .vector_ack(vector_ack), .irq_req(irq_req), .irq(irq),
  .ext_buf_en(ext_buf_en), .xtal_en(xtal_en),
  .shared_prescaler_rst(shared_prescaler_rst)
);
`default_nettype wire

// ---- bench/timer_async_ctrl_tb_top.sv ----
// Purpose: Directed APB tests of the async timer control block
// Assumes: Master waits for pready, osc source frozen on demand
// Notes: Sync-mode tests run first, async switch comes last
`timescale 1ns/1ps
`default_nettype none
module timer_async_ctrl_tb_top;
  import timer_async_pkg::*;
  localparam logic [11:0] A_STAT = {ASYNC_CLOCK_STATUS_IDX, 2'b00};
  localparam logic [11:0] A_CTRA = {CONTROL_REG_A_IDX, 2'b00};
  localparam logic [11:0] A_CTRB = {CONTROL_REG_B_IDX, 2'b00};
  localparam logic [11:0] A_CNT = {COUNTER_VALUE_IDX, 2'b00};
  localparam logic [11:0] A_CMPA = {COMPARE_VALUE_A_IDX, 2'b00};
  localparam logic [11:0] A_CMPB = {COMPARE_VALUE_B_IDX, 2'b00};
  localparam logic [11:0] A_MASK = {TIMER_B_IRQ_MASK_IDX, 2'b00};
  localparam logic [11:0] A_FLAG = {TIMER_B_IRQ_FLAGS_IDX, 2'b00};
  localparam logic [11:0] A_GTC = {GENERAL_TIMER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_EST = {EVENT_STATUS_IDX, 2'b00};
  localparam logic [11:0] A_EMSK = {EVENT_MASK_IDX, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic global_irq_en = 1'b1;
  logic [2:0] vector_ack = 3'b000;
  logic osc_hold = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_pin;
  logic [2:0] irq_req;
  logic irq;
  logic ext_buf_en;
  logic xtal_en;
  logic shared_prescaler_rst;
  logic [31:0] rdata;
  logic rerr;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [11:0] addr_tab [5];
  int bit_tab [5];
  logic [7:0] msk_tab [5];

  always #12.5 pclk = ~pclk;

  timer_async_ctrl uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_osc_input_pin(osc_pin),
    .global_irq_en(global_irq_en), .vector_ack(vector_ack),
    .irq_req(irq_req), .irq(irq), .ext_buf_en(ext_buf_en),
    .xtal_en(xtal_en), .shared_prescaler_rst(shared_prescaler_rst)
  );
  osc_source osc (.timer_osc_input_pin(osc_pin), .hold(osc_hold));

  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic is_wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check(nm, rdata, exp);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic end_sim;
    $display("Compared %0d mismatched %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    int n;
    addr_tab = '{A_CTRA, A_CTRB, A_CNT, A_CMPA, A_CMPB};
    bit_tab = '{BUSY_CTRL_A, BUSY_CTRL_B, BUSY_COUNTER, BUSY_CMP_A, BUSY_CMP_B};
    msk_tab = '{CTRL_A_MASK, CTRL_B_MASK, 8'h12, 8'hFF, 8'hFF};
    cyc(10);
    presetn <= 1'b1;
    rd_chk("status_rst", A_STAT, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 8'h00);
    check("unmapped_err", 32'(rerr), 32'h0000_0001);
    wr(A_MASK, 8'h07);
    wr(A_CMPA, 8'h40);
    wr(A_CMPB, 8'h80);
    wr(A_CTRB, 8'h01);
    n = 0;
    while (irq_req !== 3'b111 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    wr(A_CTRB, 8'h00);
    rd_chk("flags_all", A_FLAG, 32'h0000_0007);
    global_irq_en <= 1'b0;
    cyc(3);
    check("irq_gated", 32'(irq_req), 32'h0000_0000);
    global_irq_en <= 1'b1;
    wr(A_MASK, 8'h05);
    cyc(3);
    check("irq_masked", 32'(irq_req), 32'h0000_0005);
    wr(A_FLAG, 8'h00);
    rd_chk("flag_w0", A_FLAG, 32'h0000_0007);
    @(posedge pclk) vector_ack <= 3'b010;
    @(posedge pclk) vector_ack <= 3'b000;
    rd_chk("flag_ack", A_FLAG, 32'h0000_0005);
    wr(A_FLAG, 8'h04);
    rd_chk("flag_w1c", A_FLAG, 32'h0000_0001);
    wr(A_EMSK, 8'h00);
    cyc(3);
    check("irq_off", 32'(irq), 32'h0000_0000);
    wr(A_EMSK, 8'hFF);
    cyc(3);
    check("irq_on", 32'(irq), 32'h0000_0001);
    rd_chk("event_set", A_EST, 32'h0000_0007);
    rd_chk("event_clr", A_EST, 32'h0000_0000);
    cyc(3);
    check("irq_clr", 32'(irq), 32'h0000_0000);
    wr(A_GTC, 8'h01);
    rd_chk("shared_clr", A_GTC, 32'h0000_0000);
    wr(A_GTC, 8'h02);
    rd_chk("async_clr", A_GTC, 32'h0000_0000);
    wr(A_GTC, 8'h83);
    rd_chk("sync_keep", A_GTC, 32'h0000_0083);
    check("shared_held", 32'(shared_prescaler_rst), 32'h0000_0001);
    wr(A_GTC, 8'h00);
    rd_chk("sync_off", A_GTC, 32'h0000_0000);
    wr(A_CNT, 8'h12);
    rd_chk("counter_sync", A_CNT, 32'h0000_0012);
    wr(A_STAT, 8'h40);
    cyc(3);
    check("ext_only", 32'({ext_buf_en, xtal_en}), 32'h0000_0000);
    wr(A_STAT, 8'h60);
    cyc(3);
    check("ext_async", 32'({ext_buf_en, xtal_en}), 32'h0000_0002);
    rd_chk("status_rb", A_STAT, 32'h0000_0060);
    wr(A_STAT, 8'h00);
    wr(A_STAT, 8'h20);
    cyc(3);
    check("xtal_async", 32'({ext_buf_en, xtal_en}), 32'h0000_0001);
    // Prescaler held at zero until the first oscillator edge
    wr(A_GTC, 8'h02);
    rd_chk("async_psr_hold", A_GTC, 32'h0000_0002);
    // every timer register rewritten after the source switch
    for (int k = 0; k < 5; k++) begin
      osc_hold <= 1'b1;
      wr(addr_tab[k], 8'hFF);
      rd_chk("busy_set", A_STAT,
             32'h0000_0020 | (32'h0000_0001 << bit_tab[k]));
      // Counter shows its live value while the new one waits
      rd_chk("holding_rd", addr_tab[k], {24'h00_0000, msk_tab[k]});
      osc_hold <= 1'b0;
      // busy cleared before the next write
      n = 0;
      do begin
        apb(1'b0, A_STAT, 8'h00);
        n++;
      end while (rdata !== 32'h0000_0020 && n < 20);
      check("busy_clr", rdata, 32'h0000_0020);
    end
    rd_chk("counter_live", A_CNT, 32'h0000_00FF);
    rd_chk("async_psr_done", A_GTC, 32'h0000_0000);
    end_sim();
  end
endmodule : timer_async_ctrl_tb_top
`default_nettype wire

// ---- hdl/timer_async_ctrl.sv ----
// Purpose: Clock select, update-busy, interrupt flags and prescaler resets
//   of an 8-bit timer, with a small counter core, behind an APB slave
// Assumes: The timer oscillator pin is sampled on pclk, well below its rate
// Notes: One state struct, APB slave answers after one wait state
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timer_async_ctrl
  import timer_async_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_osc_input_pin,
  input wire logic global_irq_en,
  input wire logic [2:0] vector_ack,
  output logic [2:0] irq_req,
  output logic irq,
  output logic ext_buf_en,
  output logic xtal_en,
  output logic shared_prescaler_rst
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic ext_en;
    logic async_sel;
    logic [4:0] busy;
    logic [7:0] counter;
    logic [7:0] cnt_tmp;
    logic [7:0] cmp_a;
    logic [7:0] cmp_a_tmp;
    logic [7:0] cmp_b;
    logic [7:0] cmp_b_tmp;
    logic [7:0] ctl_a;
    logic [7:0] ctl_a_tmp;
    logic [7:0] ctl_b;
    logic [7:0] ctl_b_tmp;
    logic [2:0] irq_en;
    logic [2:0] flags;
    logic sync_hold_mode;
    logic psr_async;
    logic psr_sync;
    logic [9:0] prescale;
    logic count_down;
    logic match_block;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [2:0] evt;
    logic [2:0] evt_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] irq_req;
    logic irq;
    logic ext_buf_en;
    logic xtal_en;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ==========================================================================
  // Helpers
  function automatic logic div_tick(input logic [2:0] cs,
                                    input logic [9:0] pre);
    unique case (cs)
      3'b000: div_tick = 1'b0;
      3'b001: div_tick = 1'b1;
      3'b010: div_tick = &pre[2:0];
      3'b011: div_tick = &pre[4:0];
      3'b100: div_tick = &pre[5:0];
      3'b101: div_tick = &pre[6:0];
      3'b110: div_tick = &pre[7:0];
      3'b111: div_tick = &pre[9:0];
    endcase
  endfunction : div_tick

  function automatic logic hit(input logic [11:0] addr,
                               input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  logic access;
  logic wr_done;
  logic rd_done;
  logic src_tick;
  logic cnt_tick;
  logic async_wr;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] top;
  logic [7:0] rd_byte;
  logic [2:0] set_evt;
  logic [2:0] w1c;
  wave_mode_type mode;

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    access = psel && penable;
    wr_done = access && state_reg.pready && pwrite;
    rd_done = access && state_reg.pready && !pwrite;
    wbyte = pwdata[7:0];
    async_wr = wr_done && state_reg.async_sel;
    mode = wave_mode_type'({state_reg.ctl_b[WGM2_BIT], state_reg.ctl_a[1:0]});
    set_evt = 3'b000;
    w1c = 3'b000;

    state_next.osc_s1 = timer_osc_input_pin;
    state_next.osc_s2 = state_reg.osc_s1;
    state_next.osc_s3 = state_reg.osc_s2;

    src_tick = state_reg.async_sel ? (state_reg.osc_s2 && !state_reg.osc_s3)
                                   : 1'b1;
    cnt_tick = src_tick && !state_reg.psr_async &&
               div_tick(state_reg.ctl_b[2:0], state_reg.prescale);

    // Prescaler, held while its reset bit stands
    if (state_reg.psr_async) begin
      state_next.prescale = 10'h000;
    end else if (src_tick) begin
      state_next.prescale = state_reg.prescale + 10'h001;
    end

    top = (mode == MODE_CTC || mode == MODE_PC_CMP || mode == MODE_FAST_CMP)
          ? state_reg.cmp_a : COUNT_MAX;

    // Counter core
    if (cnt_tick) begin
      state_next.match_block = 1'b0;
      if (!state_reg.match_block) begin
        if (state_reg.counter == state_reg.cmp_a) begin
          set_evt[COMPARE_A_BIT] = 1'b1;
        end
        if (state_reg.counter == state_reg.cmp_b) begin
          set_evt[COMPARE_B_BIT] = 1'b1;
        end
      end
      unique case (mode)
        MODE_PC_FF, MODE_PC_CMP: begin
          if (!state_reg.count_down) begin
            if (state_reg.counter >= top) begin
              state_next.count_down = 1'b1;
              state_next.counter = state_reg.counter - 8'h01;
            end else begin
              state_next.counter = state_reg.counter + 8'h01;
            end
          end else if (state_reg.counter == COUNT_BOTTOM) begin
            set_evt[OVERFLOW_BIT] = 1'b1;
            state_next.count_down = 1'b0;
            state_next.counter = state_reg.counter + 8'h01;
          end else begin
            state_next.counter = state_reg.counter - 8'h01;
          end
        end
        default: begin
          state_next.count_down = 1'b0;
          if (state_reg.counter == top) begin
            state_next.counter = COUNT_BOTTOM;
            if (mode != MODE_CTC || top == COUNT_MAX) begin
              set_evt[OVERFLOW_BIT] = 1'b1;
            end
          end else begin
            state_next.counter = state_reg.counter + 8'h01;
          end
        end
      endcase
    end

    // holding registers move over on an oscillator edge
    if (state_reg.async_sel && src_tick) begin
      if (state_reg.busy[BUSY_COUNTER]) begin
        state_next.counter = state_reg.cnt_tmp;
        state_next.match_block = 1'b1;
      end
      state_next.cmp_a = state_reg.cmp_a_tmp;
      state_next.cmp_b = state_reg.cmp_b_tmp;
      state_next.ctl_a = state_reg.ctl_a_tmp;
      state_next.ctl_b = state_reg.ctl_b_tmp;
      state_next.busy = 5'b00000;
    end
    if (!state_reg.async_sel) begin
      state_next.busy = 5'b00000;
    end

    w1c = vector_ack;

    // async prescaler reset completes on source edge
    if (state_reg.psr_async && !state_reg.sync_hold_mode && src_tick) begin
      state_next.psr_async = 1'b0;
    end
    // shared reset is a one-cycle pulse outside sync mode
    if (state_reg.psr_sync && !state_reg.sync_hold_mode) begin
      state_next.psr_sync = 1'b0;
    end

    // ========================================================================
    // APB slave: two-cycle access, pready from a flop
    mapped = hit(paddr, ASYNC_CLOCK_STATUS_IDX) ||
             hit(paddr, CONTROL_REG_A_IDX) || hit(paddr, CONTROL_REG_B_IDX) ||
             hit(paddr, COUNTER_VALUE_IDX) || hit(paddr, COMPARE_VALUE_A_IDX) ||
             hit(paddr, COMPARE_VALUE_B_IDX) ||
             hit(paddr, TIMER_B_IRQ_MASK_IDX) ||
             hit(paddr, TIMER_B_IRQ_FLAGS_IDX) ||
             hit(paddr, GENERAL_TIMER_CONTROL_IDX) ||
             hit(paddr, EVENT_STATUS_IDX) || hit(paddr, EVENT_MASK_IDX);
    rd_byte = 8'h00;
    if (hit(paddr, ASYNC_CLOCK_STATUS_IDX)) begin
      rd_byte = {1'b0, state_reg.ext_en, state_reg.async_sel, state_reg.busy};
    end
    // live counter, holding copies for compare and control registers
    if (hit(paddr, COUNTER_VALUE_IDX)) begin
      rd_byte = state_reg.counter;
    end
    if (hit(paddr, COMPARE_VALUE_A_IDX)) begin
      rd_byte = state_reg.cmp_a_tmp;
    end
    if (hit(paddr, COMPARE_VALUE_B_IDX)) begin
      rd_byte = state_reg.cmp_b_tmp;
    end
    if (hit(paddr, CONTROL_REG_A_IDX)) begin
      rd_byte = state_reg.ctl_a_tmp;
    end
    if (hit(paddr, CONTROL_REG_B_IDX)) begin
      rd_byte = state_reg.ctl_b_tmp;
    end
    if (hit(paddr, TIMER_B_IRQ_MASK_IDX)) begin
      rd_byte = {5'b00000, state_reg.irq_en};
    end
    if (hit(paddr, TIMER_B_IRQ_FLAGS_IDX)) begin
      rd_byte = {5'b00000, state_reg.flags};
    end
    if (hit(paddr, GENERAL_TIMER_CONTROL_IDX)) begin
      rd_byte = {state_reg.sync_hold_mode, 5'b00000, state_reg.psr_async,
                 state_reg.psr_sync};
    end
    if (hit(paddr, EVENT_STATUS_IDX)) begin
      rd_byte = {5'b00000, state_reg.evt};
    end
    if (hit(paddr, EVENT_MASK_IDX)) begin
      rd_byte = {5'b00000, state_reg.evt_mask};
    end

    state_next.pready = access && !state_reg.pready;
    if (access && !state_reg.pready) begin
      state_next.pslverr = !mapped;
      state_next.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end

    // Reading the event register clears it; new events still land below
    if (rd_done && hit(paddr, EVENT_STATUS_IDX)) begin
      state_next.evt = 3'b000;
    end

    if (wr_done) begin
      if (hit(paddr, ASYNC_CLOCK_STATUS_IDX)) begin
        state_next.ext_en = wbyte[EXT_CLOCK_INPUT_EN_BIT];
        // source change leaves timer registers as they stand
        state_next.async_sel = wbyte[ASYNC_CLOCK_SELECT_BIT];
      end
      // writes land in holding registers and raise busy only with the async clock selected
      if (hit(paddr, COUNTER_VALUE_IDX)) begin
        state_next.cnt_tmp = wbyte;
        state_next.busy[BUSY_COUNTER] = async_wr;
        if (!state_reg.async_sel) begin
          state_next.counter = wbyte;
          state_next.match_block = 1'b1;
        end
      end
      if (hit(paddr, COMPARE_VALUE_A_IDX)) begin
        state_next.cmp_a_tmp = wbyte;
        state_next.busy[BUSY_CMP_A] = async_wr;
      end
      if (hit(paddr, COMPARE_VALUE_B_IDX)) begin
        state_next.cmp_b_tmp = wbyte;
        state_next.busy[BUSY_CMP_B] = async_wr;
      end
      if (hit(paddr, CONTROL_REG_A_IDX)) begin
        state_next.ctl_a_tmp = wbyte & CTRL_A_MASK;
        state_next.busy[BUSY_CTRL_A] = async_wr;
      end
      if (hit(paddr, CONTROL_REG_B_IDX)) begin
        state_next.ctl_b_tmp = wbyte & CTRL_B_MASK;
        state_next.busy[BUSY_CTRL_B] = async_wr;
      end
      if (hit(paddr, TIMER_B_IRQ_MASK_IDX)) begin
        state_next.irq_en = wbyte[2:0];
      end
      if (hit(paddr, TIMER_B_IRQ_FLAGS_IDX)) begin
        w1c = w1c | wbyte[2:0];
      end
      if (hit(paddr, EVENT_MASK_IDX)) begin
        state_next.evt_mask = wbyte[2:0];
      end
      if (hit(paddr, GENERAL_TIMER_CONTROL_IDX)) begin
        state_next.sync_hold_mode = wbyte[SYNC_HOLD_MODE_BIT];
        if (wbyte[ASYNC_PRESCALER_RESET_BIT]) begin
          state_next.psr_async = 1'b1;
        end
        if (wbyte[SHARED_PRESCALER_RESET_BIT]) begin
          state_next.psr_sync = 1'b1;
        end
        // leaving sync mode releases both resets together
        if (!wbyte[SYNC_HOLD_MODE_BIT] && state_reg.sync_hold_mode) begin
          state_next.psr_async = 1'b0;
          state_next.psr_sync = 1'b0;
        end
      end
    end

    // Sync-clocked prescaler reset finishes at once
    if (!state_reg.async_sel && !state_next.sync_hold_mode && state_reg.psr_async) begin
      state_next.psr_async = 1'b0;
    end

    // Non-async writes update live copies straight away
    if (!state_reg.async_sel) begin
      state_next.cmp_a = state_next.cmp_a_tmp;
      state_next.cmp_b = state_next.cmp_b_tmp;
      state_next.ctl_a = state_next.ctl_a_tmp;
      state_next.ctl_b = state_next.ctl_b_tmp;
    end

    // Set wins over any clear in the same cycle
    state_next.flags = (state_reg.flags & ~w1c) | set_evt;
    state_next.evt = state_next.evt | set_evt;

    // request gated by enable, global bit and flag
    state_next.irq_req = state_next.flags & state_next.irq_en &
                         {3{global_irq_en}};
    state_next.irq = |(state_next.evt & state_next.evt_mask);

    state_next.ext_buf_en = state_next.ext_en && state_next.async_sel;
    state_next.xtal_en = !state_next.ext_en && state_next.async_sel;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq_req = state_reg.irq_req;
  assign irq = state_reg.irq;
  assign ext_buf_en = state_reg.ext_buf_en;
  assign xtal_en = state_reg.xtal_en;
  assign shared_prescaler_rst = state_reg.psr_sync;
endmodule : timer_async_ctrl
`default_nettype wire

// ---- hdl/timer_async_pkg.sv ----
// Purpose: Constants for the asynchronous 8-bit timer control block
// Assumes: APB with 32-bit data, each register index times four is its address
// Notes: Register indices are kept as printed; byte address is index * 4
package timer_async_pkg;
  // ==========================================================================
  // Register indices
  localparam logic [9:0] ASYNC_CLOCK_STATUS_IDX = 10'h0_B6;
  localparam logic [9:0] CONTROL_REG_A_IDX = 10'h0_B0;
  localparam logic [9:0] CONTROL_REG_B_IDX = 10'h0_B1;
  localparam logic [9:0] COUNTER_VALUE_IDX = 10'h0_B2;
  localparam logic [9:0] COMPARE_VALUE_A_IDX = 10'h0_B3;
  localparam logic [9:0] COMPARE_VALUE_B_IDX = 10'h0_B4;
  localparam logic [9:0] TIMER_B_IRQ_MASK_IDX = 10'h0_70;
  localparam logic [9:0] TIMER_B_IRQ_FLAGS_IDX = 10'h0_37;
  localparam logic [9:0] GENERAL_TIMER_CONTROL_IDX = 10'h0_43;
  localparam logic [9:0] EVENT_STATUS_IDX = 10'h0_C0;
  localparam logic [9:0] EVENT_MASK_IDX = 10'h0_C1;
  // ==========================================================================
  // Field positions
  localparam int EXT_CLOCK_INPUT_EN_BIT = 6;
  localparam int ASYNC_CLOCK_SELECT_BIT = 5;
  localparam int BUSY_LSB = 0;
  localparam int OVERFLOW_BIT = 0;
  localparam int COMPARE_A_BIT = 1;
  localparam int COMPARE_B_BIT = 2;
  localparam int SYNC_HOLD_MODE_BIT = 7;
  localparam int ASYNC_PRESCALER_RESET_BIT = 1;
  localparam int SHARED_PRESCALER_RESET_BIT = 0;
  localparam int WGM2_BIT = 3;
  // Busy flag positions inside the five-bit busy field
  localparam int BUSY_CTRL_B = 0;
  localparam int BUSY_CTRL_A = 1;
  localparam int BUSY_CMP_B = 2;
  localparam int BUSY_CMP_A = 3;
  localparam int BUSY_COUNTER = 4;
  // ==========================================================================
  // Reset values and constants
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0F;
  // ==========================================================================
  // Waveform modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PC_FF = 3'b001,
    MODE_CTC = 3'b010,
    MODE_FAST_FF = 3'b011,
    MODE_RSVD_4 = 3'b100,
    MODE_PC_CMP = 3'b101,
    MODE_RSVD_6 = 3'b110,
    MODE_FAST_CMP = 3'b111
  } wave_mode_type;
endpackage : timer_async_pkg
